// ---- sar_pkg.sv ----
// Shared constants and types for the serial readout of the successive approximation converter.
package sar_pkg;

    // System clock rate that all cycle counts are derived from.
    localparam int unsigned SYS_CLK_HZ      = 50_000_000;
    // Longest conversion time in nanoseconds.
    localparam int unsigned T_CONV_MAX_NS   = 400;
    // Conversion time in system clock cycles, rounded up so a conversion is never short.
    localparam int unsigned CONV_CYCLES     =
        (T_CONV_MAX_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;

    // Width of one conversion result.
    localparam int unsigned RESULT_BITS     = 16;
    // Width of the output shift register: one start bit in front of the result.
    localparam int unsigned SHIFT_BITS      = RESULT_BITS + 1;
    // Depth of the result queue between the converter core and the readout.
    localparam int unsigned FIFO_DEPTH      = 16;
    // Flip-flops in every pin synchroniser.
    localparam int unsigned SYNC_STAGES     = 2;

    // Falling clock edges that end a plain read and a read with busy start bit.
    localparam logic [4:0]  PLAIN_READ_EDGES = 5'h10;
    localparam logic [4:0]  BUSY_READ_EDGES  = 5'h11;
    // Reset values of the shift register and of the edge counter.
    localparam logic [SHIFT_BITS-1:0] SHIFT_RESET = 17'h0_0000;
    localparam logic [4:0]  EDGE_RESET      = 5'h00;
    // Start bit levels that announce the end of a conversion.
    localparam logic        CS_START_BIT    = 1'b0;
    localparam logic        CHAIN_START_BIT = 1'b1;

    // Readout state machine, one-hot.
    typedef enum logic [3:0] {
        SAR_IDLE  = 4'b0001,  // Acquisition, no result pending.
        SAR_CONV  = 4'b0010,  // Conversion running, output released.
        SAR_WAIT  = 4'b0100,  // Result held, waiting for a read select.
        SAR_SHIFT = 4'b1000   // Result being shifted out.
    } sar_state_e;

endpackage

// ---- sar_sync.sv ----
// Two-stage synchroniser for a group of asynchronous pins.
`timescale 1ns/1ps
module sar_sync #(
    parameter int unsigned WIDTH = 4             // Number of pins synchronised.
) (
    input  wire logic             clk_i,         // Sampling clock.
    input  wire logic             rst_n_i,       // Active low asynchronous reset.
    input  wire logic [WIDTH-1:0] async_i,       // Pins from outside the clock domain.
    output logic      [WIDTH-1:0] sync_o         // Synchronised copy.
);
    import sar_pkg::*;

    logic [WIDTH-1:0] meta;                      // First stage, read by the second only.

    // The first stage may go metastable; only the second stage looks at it.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end

endmodule

// ---- sar_fifo.sv ----
// Result queue with a registered output word and valid/ready on both sides.
`timescale 1ns/1ps
module sar_fifo #(
    parameter int unsigned WIDTH = 16,           // Word width.
    parameter int unsigned DEPTH = 16            // Words held in the memory.
) (
    input  wire logic             clk_i,         // System clock.
    input  wire logic             rst_n_i,       // Active low asynchronous reset.
    input  wire logic [WIDTH-1:0] in_data_i,     // Word offered by the source.
    input  wire logic             in_valid_i,    // Source has a word.
    output logic                  in_ready_o,    // Queue can take a word.
    output logic      [WIDTH-1:0] out_data_o,    // Head word, registered.
    output logic                  out_valid_o,   // Head word is valid.
    input  wire logic             out_ready_i    // Sink takes the head word.
);
    import sar_pkg::*;

    localparam int unsigned AW = $clog2(DEPTH);  // Pointer width.

    logic [WIDTH-1:0] mem [DEPTH];               // Storage behind the output register.
    logic [AW-1:0]    wr_ptr;                    // Next slot to write.
    logic [AW-1:0]    rd_ptr;                    // Next slot to read.
    logic [AW:0]      count;                     // Words held in the memory.

    wire              push      = in_valid_i & in_ready_o;
    wire              head_free = ~out_valid_o | out_ready_i;
    wire              pull      = head_free & (count != '0);
    wire [AW:0]       next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pull};

    // Storage write; the memory has no reset, only the pointers, fill level, ready flag and output register do.
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers, fill level and a registered full flag so that ready is a flop.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr     <= '0;
            rd_ptr     <= '0;
            count      <= '0;
            in_ready_o <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pull) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count      <= next_count;
            in_ready_o <= (next_count != (AW+1)'(DEPTH));
        end
    end

    // Output register refills from the memory whenever the head is taken or empty and the memory holds a word.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_data_o  <= '0;
            out_valid_o <= 1'b0;
        end else if (pull) begin
            out_data_o  <= mem[rd_ptr];
            out_valid_o <= 1'b1;
        end else if (out_ready_i) begin
            out_valid_o <= 1'b0;
        end
    end

endmodule

// ---- sar_readout_top.sv ----
// Conversion start, mode selection and serial readout of the converter.
`timescale 1ns/1ps
module sar_readout_top (
    input  wire logic                             sys_clk_i,            // System clock.
    input  wire logic                             rst_n_i,              // Async reset, low.
    input  wire logic                             convert_start_i,      // Start pin.
    input  wire logic                             serial_data_in_i,     // Data in / select pin.
    input  wire logic                             sck_i,                // Host shift clock pin.
    input  wire logic                             high_rate_select_i,   // High rate pin.
    input  wire logic [sar_pkg::RESULT_BITS-1:0]  sample_data_i,        // Core result word.
    input  wire logic                             sample_valid_i,       // Core word valid.
    output logic                                  sample_ready_o,       // Queue accepts word.
    output logic                                  serial_data_out_o,    // Output pin level.
    output logic                                  serial_data_out_oe_o, // Output pin enable.
    output logic                                  converter_on_o        // Converter powered.
);
    import sar_pkg::*;

    localparam int unsigned CNT_W = $clog2(CONV_CYCLES + 1);        // Conversion timer width.
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1); // Last timer value.

    // Reset release synchroniser.
    logic                    rst_meta;           // First reset stage.
    logic                    rst_n;              // Released reset used by all logic.

    // Synchronised pins and their previous values.
    logic [3:0]              pins_s;             // Synchronised pins.
    logic                    cnv_d;              // Start pin, one cycle older.
    logic                    sdi_d;              // Data input, one cycle older.
    logic                    sck_d;              // Shift clock, one cycle older.

    // Control state.
    sar_state_e              state;              // Readout state.
    sar_state_e              next_state;         // Next readout state.
    logic [CNT_W-1:0]        conv_cnt;           // Cycles spent converting.
    logic                    chain_mode;         // Chain mode selected at start.
    logic                    busy_allow;         // Busy start bit permitted.
    logic                    read_busy;          // Current read carries a start bit.
    logic [SHIFT_BITS-1:0]   shift_reg;          // Output shift register.
    logic [4:0]              edge_cnt;           // Falling edges seen during a read.

    // Result queue head.
    logic [RESULT_BITS-1:0]  q_data;             // Result at the queue head.
    logic                    q_valid;            // Queue head valid.

    // The released reset asserts at once and releases two edges later.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // All host pins arrive unrelated to the system clock.
    sar_sync #(
        .WIDTH (4)
    ) u_sync (
        .clk_i   (sys_clk_i),
        .rst_n_i (rst_n),
        .async_i ({high_rate_select_i, sck_i, serial_data_in_i, convert_start_i}),
        .sync_o  (pins_s)
    );

    // Named views of the synchronised pins.
    wire cnv_s = pins_s[0];
    wire sdi_s = pins_s[1];
    wire sck_s = pins_s[2];
    wire hrs_s = pins_s[3];

    // Edge detection works on the second synchroniser stage only.
    wire cnv_rise    = cnv_s & ~cnv_d;
    wire sck_fall    = ~sck_s & sck_d;
    // Either pin low selects the read: start in three-wire, data input in four-wire.
    wire sel_act     = ~(cnv_s & sdi_s);
    wire sel_prev    = ~(cnv_d & sdi_d);
    wire sel_fall    = sel_act & ~sel_prev;
    wire sel_rise    = ~sel_act & sel_prev;

    // State decodes.
    wire in_idle     = (state == SAR_IDLE);
    wire in_conv     = (state == SAR_CONV);
    wire in_wait     = (state == SAR_WAIT);
    wire in_shift    = (state == SAR_SHIFT);

    // A new start is ignored while converting so the conversion always completes.
    wire conv_start  = cnv_rise & ~in_conv;
    // The conversion ends at the timer limit once the core has a result ready.
    wire conv_end    = in_conv & (conv_cnt == CONV_LAST) & q_valid;
    // Busy start bit: chain uses the clock captured at start, select mode the
    // select level at the end; never in the high rate mode.
    wire busy_now    = busy_allow & (chain_mode | sel_act) & ~hrs_s;
    wire [4:0] read_len = read_busy ? BUSY_READ_EDGES : PLAIN_READ_EDGES;
    // Select-mode reads end at the last edge or when the select goes away.
    wire last_edge   = sck_fall & (edge_cnt == read_len - 5'h01);
    wire read_done   = in_shift & ~chain_mode & (last_edge | sel_rise);
    // Chain mode feeds the data input into the bottom of the register after a busy load, and into the bit above the pad bit after a plain load.
    wire shift_in    = chain_mode & sdi_s;
    wire start_bit   = chain_mode ? CHAIN_START_BIT : CS_START_BIT;

    // Shift register load at conversion end and shift on falling edges.
    wire [SHIFT_BITS-1:0] load_word  = busy_now ? {start_bit, q_data}
                                                : {q_data, 1'b0};
    // A plain load keeps a pad bit at the bottom, so chain input enters above it;
    // otherwise the next converter's first bit would trail the LSB by one edge.
    wire [SHIFT_BITS-1:0] shifted    = read_busy ? {shift_reg[SHIFT_BITS-2:0], shift_in}
                                                 : {shift_reg[SHIFT_BITS-2:1], shift_in, 1'b0};
    wire [SHIFT_BITS-1:0] next_shift =
        conv_end                  ? load_word :
        (in_shift & sck_fall)     ? shifted :
                                    shift_reg;

    // Next state decode.
    always_comb begin
        next_state = state;
        unique case (state)
            SAR_IDLE: begin
                if (conv_start) begin
                    next_state = SAR_CONV;
                end
            end
            SAR_CONV: begin
                if (conv_end) begin
                    // Chain reads and reads with the select low at the end start driving at once; others wait.
                    next_state = (chain_mode | sel_act) ? SAR_SHIFT : SAR_WAIT;
                end
            end
            SAR_WAIT: begin
                if (conv_start) begin
                    next_state = SAR_CONV;
                end else if (sel_fall) begin
                    next_state = SAR_SHIFT;
                end
            end
            SAR_SHIFT: begin
                if (conv_start) begin
                    next_state = SAR_CONV;
                end else if (read_done) begin
                    next_state = SAR_IDLE;
                end
            end
            default: begin
                next_state = SAR_IDLE;
            end
        endcase
    end

    // Output pin values follow the next state so they leave flip-flops directly.
    wire next_idle_low = (next_state == SAR_IDLE) & ~cnv_s & ~sdi_s;
    wire next_oe       = (next_state == SAR_SHIFT) | next_idle_low;
    wire next_sdo      = (next_state == SAR_SHIFT) & next_shift[SHIFT_BITS-1];
    // The converter is powered only while a conversion runs.
    wire next_conv_on  = (next_state == SAR_CONV);

    // Delayed pin copies for edge detection.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cnv_d <= 1'b0;
            sdi_d <= 1'b0;
            sck_d <= 1'b0;
        end else begin
            cnv_d <= cnv_s;
            sdi_d <= sdi_s;
            sck_d <= sck_s;
        end
    end

    // State register.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= SAR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Conversion timer; it holds at the limit while the core result is late.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            conv_cnt <= '0;
        end else if (conv_start) begin
            conv_cnt <= '0;
        end else if (in_conv & (conv_cnt != CONV_LAST)) begin
            conv_cnt <= conv_cnt + 1'b1;
        end
    end

    // Mode capture at the start edge: data input low picks chain mode, and in
    // chain mode a low shift clock disables the start bit.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            chain_mode <= 1'b0;
            busy_allow <= 1'b0;
        end else if (conv_start) begin
            chain_mode <= ~sdi_s;
            busy_allow <= sdi_s | sck_s;
        end
    end

    // Read bookkeeping: start bit flag and edge count.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            read_busy <= 1'b0;
            edge_cnt  <= EDGE_RESET;
        end else if (conv_end) begin
            read_busy <= busy_now;
            edge_cnt  <= EDGE_RESET;
        end else if (in_shift & sck_fall & (edge_cnt != BUSY_READ_EDGES)) begin
            edge_cnt  <= edge_cnt + 5'h01;
        end
    end

    // Shift register; it only changes at a load or a falling edge while reading.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= SHIFT_RESET;
        end else begin
            shift_reg <= next_shift;
        end
    end

    // Registered pin outputs.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            serial_data_out_o    <= 1'b0;
            serial_data_out_oe_o <= 1'b0;
            converter_on_o       <= 1'b0;
        end else begin
            serial_data_out_o    <= next_sdo;
            serial_data_out_oe_o <= next_oe;
            converter_on_o       <= next_conv_on;
        end
    end

    // Results wait here; a full queue back-pressures the converter core, and an
    // empty one stretches the conversion until a word arrives.
    sar_fifo #(
        .WIDTH (RESULT_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (sys_clk_i),
        .rst_n_i     (rst_n),
        .in_data_i   (sample_data_i),
        .in_valid_i  (sample_valid_i),
        .in_ready_o  (sample_ready_o),
        .out_data_o  (q_data),
        .out_valid_o (q_valid),
        .out_ready_i (conv_end)
    );

    // Checks on the readout behaviour.
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_start;
        conv_start;
    endsequence

    sequence s_released_conv;
        in_conv && !serial_data_out_oe_o && converter_on_o;
    endsequence

    sequence s_busy_end;
        conv_end && busy_now;
    endsequence

    start_release_a: assert property (s_start |=> s_released_conv)
        else $error("Start edge did not release the output.");

    conv_hiz_a: assert property (in_conv |-> !serial_data_out_oe_o)
        else $error("Output driven during conversion.");

    busy_flag_a: assert property (s_busy_end |=> serial_data_out_oe_o &&
        serial_data_out_o == $past(start_bit))
        else $error("Conversion end did not show the start bit.");

    power_down_a: assert property (conv_end |=> !converter_on_o)
        else $error("Converter stayed powered after conversion.");

    msb_first_a: assert property (conv_end && !busy_now && chain_mode |=>
        serial_data_out_o == $past(q_data[RESULT_BITS-1]))
        else $error("First bit out was not the MSB.");

    shift_step_a: assert property (in_shift && sck_fall && !read_done && !conv_start |=>
        serial_data_out_o == $past(shift_reg[SHIFT_BITS-2]) && serial_data_out_oe_o)
        else $error("Output did not advance one bit on a falling edge.");

    busy_release_a: assert property (in_shift && read_busy && !chain_mode && sck_fall &&
        edge_cnt == 5'h10 && !conv_start |=> !serial_data_out_oe_o [*2])
        else $error("Busy read not released after the seventeenth edge.");

    plain_release_a: assert property (in_shift && !read_busy && !chain_mode && sck_fall &&
        edge_cnt == 5'h0f && !conv_start |=> !serial_data_out_oe_o)
        else $error("Plain read not released after the sixteenth edge.");

    deselect_a: assert property (in_shift && !chain_mode && sel_rise && !conv_start |=>
        !serial_data_out_oe_o)
        else $error("Output still driven after deselect.");

    idle_low_a: assert property (in_idle && !cnv_s && !sdi_s |=>
        serial_data_out_oe_o && !serial_data_out_o)
        else $error("Output not driven low with both inputs low.");

    mode_pick_a: assert property (s_start |=> chain_mode == !$past(sdi_s) &&
        busy_allow == ($past(sdi_s) || $past(sck_s)))
        else $error("Mode not captured at the start edge.");

    read_select_a: assert property (in_wait && sel_fall && !conv_start |=>
        serial_data_out_oe_o && serial_data_out_o == $past(shift_reg[SHIFT_BITS-1]))
        else $error("Read select did not put the MSB out.");

    hold_result_a: assert property (in_wait |=> $stable(shift_reg))
        else $error("Held result changed before readout.");

    high_rate_a: assert property (conv_end && hrs_s |-> !busy_now)
        else $error("Start bit produced in high rate mode.");

endmodule

// ---- sar_host_model.sv ----
// Behavioural digital host that paces the start, select and shift clock pins.
`timescale 1ns/1ps
module sar_host_model (
    input  wire logic clk_i,     // System clock that paces the pins.
    input  wire logic sdo_i,     // Output pin level from the device.
    input  wire logic sdo_oe_i,  // Output pin enable from the device.
    output logic      cnv_o,     // Start pin.
    output logic      sdi_o,     // Select or chain data pin.
    output logic      sck_o,     // Shift clock, still between frames.
    output logic      rate_o,    // High rate pin, low except while set_rate raises it for the high rate read.
    output wire logic line_o     // Data line as the host sees it.
);
    // A released line floats up through the pull-up, so the busy edge is a fall.
    assign line_o = sdo_oe_i ? sdo_i : 1'b1;

    // Pins start idle with the select high and the clock still.
    initial begin
        cnv_o = 1'b0;
        sdi_o = 1'b1;
        sck_o = 1'b0;
        rate_o = 1'b0;
    end

    // Sets all three pins together and holds them long enough to be seen.
    task automatic pins(input logic c, input logic d, input logic s);
        @(posedge clk_i);
        cnv_o <= c;
        sdi_o <= d;
        sck_o <= s;
        repeat (6) @(posedge clk_i);
    endtask

    // Changes the high rate pin at the next clock edge.
    task automatic set_rate(input logic r);
        @(posedge clk_i);
        rate_o <= r;
    endtask

    // One 160 ns clock period: falls, then rises, leaving the clock high.
    task automatic fall();
        @(posedge clk_i);
        sck_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        sck_o <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask
endmodule

// ---- tb_top.sv ----
// Self-checking testbench for the converter's serial readout.
`timescale 1ns/1ps
module tb_top;
    import sar_pkg::*;
    logic        sys_clk = 1'b0;  // System clock.
    logic        rst_n   = 1'b0;  // Reset, active low.
    logic        valid   = 1'b0;  // Core word valid.
    logic        ready;           // Queue has room.
    logic        serial_data_out;             // Device output level.
    logic        oe;              // Device output enable.
    logic        conv_on;         // Converter powered.
    logic        convert_start;             // Start pin.
    logic        serial_data_in;             // Select pin.
    logic        sck;             // Shift clock.
    logic        rate;            // High rate pin.
    wire logic   line;            // Resolved data line.
    int          n_fail = 0;      // Mismatches seen.
    int          checks_done = 0; // Comparisons made.
    int          pushed = 0;      // Words taken by the queue.
    int          nconv = 0;       // Results read so far.

    // Words are a function of their index, so order can be checked cheaply.
    function automatic logic [15:0] word_of(input int k);
        return 16'ha5c3 ^ 16'(k * 37);
    endfunction

    always #10 sys_clk = ~sys_clk;

    // The core offers words continuously; the queue refuses once full.
    always @(posedge sys_clk) begin
        if (valid && ready) begin
            pushed <= pushed + 1;
        end
    end

    sar_readout_top i_sar_readout_top (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
        .convert_start_i(convert_start), .serial_data_in_i(serial_data_in), .sck_i(sck),
        .high_rate_select_i(rate), .sample_data_i(word_of(pushed)), .sample_valid_i(valid),
        .sample_ready_o(ready), .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(oe),
        .converter_on_o(conv_on));
    sar_host_model i_sar_host_model (.clk_i(sys_clk), .sdo_i(serial_data_out), .sdo_oe_i(oe),
        .cnv_o(convert_start), .sdi_o(serial_data_in), .sck_o(sck), .rate_o(rate), .line_o(line));

    // Compares and counts; padded to 17 bits so one task serves pins and words.
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Waits for the busy fall on the pulled-up line, bounded so a hang ends the run.
    task automatic wait_busy();
        for (int k = 0; line !== 1'b0; k++) begin
            if (k == 100) begin
                n_fail++;
                results();
            end
            @(posedge sys_clk);
        end
    endtask

    // Checks each bit while the clock is high, then applies one falling edge.
    task automatic read(input logic [16:0] bits, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            chk({oe, line}, {1'b1, bits[i]});
            i_sar_host_model.fall();
        end
    endtask

    // Four-wire read without busy: timed wait, select fall, sixteen edges.
    task automatic s_plain();
        i_sar_host_model.pins(1'b1, 1'b1, 1'b0);
        chk({oe, conv_on}, 2'b01);
        i_sar_host_model.pins(1'b1, 1'b0, 1'b0);
        i_sar_host_model.pins(1'b1, 1'b1, 1'b0);
        repeat (30) @(posedge sys_clk);
        chk({oe, conv_on}, 2'b00);
        i_sar_host_model.pins(1'b1, 1'b0, 1'b1);
        read(word_of(nconv), 16);
        chk(oe, 1'b0);
        nconv++;
        $display("Done: four-wire plain read");
    endtask

    // Four-wire read with busy: start bit and result, release when select rises early.
    task automatic s_busy4();
        logic [15:0] w;
        w = word_of(nconv);
        i_sar_host_model.pins(1'b0, 1'b1, 1'b0);
        i_sar_host_model.pins(1'b1, 1'b1, 1'b0);
        i_sar_host_model.pins(1'b1, 1'b0, 1'b0);
        wait_busy();
        i_sar_host_model.pins(1'b1, 1'b0, 1'b1);
        read({2'b00, w[15:1]}, 16);
        chk({oe, line}, {1'b1, w[0]});
        i_sar_host_model.pins(1'b1, 1'b1, 1'b1);
        chk(oe, 1'b0);
        nconv++;
        $display("Done: four-wire busy read");
    endtask

    // High rate mode: select low at the end gives no start bit, the MSB comes first.
    task automatic s_fast();
        i_sar_host_model.set_rate(1'b1);
        i_sar_host_model.pins(1'b0, 1'b1, 1'b0);
        i_sar_host_model.pins(1'b1, 1'b1, 1'b0);
        i_sar_host_model.pins(1'b1, 1'b0, 1'b0);
        repeat (30) @(posedge sys_clk);
        i_sar_host_model.pins(1'b1, 1'b0, 1'b1);
        read(word_of(nconv), 16);
        chk(oe, 1'b0);
        i_sar_host_model.set_rate(1'b0);
        nconv++;
        $display("Done: high rate read");
    endtask

    // Three-wire read with busy: start low mid-conversion, seventeen edges.
    task automatic s_busy3();
        i_sar_host_model.pins(1'b0, 1'b1, 1'b0);
        i_sar_host_model.pins(1'b1, 1'b1, 1'b0);
        i_sar_host_model.pins(1'b0, 1'b1, 1'b0);
        chk(oe, 1'b0);
        wait_busy();
        i_sar_host_model.pins(1'b0, 1'b1, 1'b1);
        read({1'b0, word_of(nconv)}, 17);
        chk(oe, 1'b0);
        nconv++;
        $display("Done: three-wire busy read");
    endtask

    // Chain mode: select low at start, ones shifted in behind the result.
    task automatic s_chain();
        i_sar_host_model.pins(1'b0, 1'b0, 1'b0);
        chk({oe, line}, 2'b10);
        i_sar_host_model.pins(1'b1, 1'b0, 1'b0);
        repeat (30) @(posedge sys_clk);
        i_sar_host_model.pins(1'b1, 1'b1, 1'b1);
        read(word_of(nconv), 16);
        chk({oe, line}, 2'b11);
        i_sar_host_model.pins(1'b0, 1'b1, 1'b0);
        $display("Done: chain read");
    endtask

    // Reset, fill the queue until it refuses, then run the reads.
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        valid <= 1'b1;
        repeat (40) @(posedge sys_clk);
        chk({ready, 16'(pushed)}, {1'b0, 16'h0011});
        s_plain();
        s_busy4();
        s_fast();
        s_busy3();
        s_chain();
        results();
    end
endmodule
